// >>> common/sacc_cfg.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  converter control block. Assumes a 32-bit APB slave with word-aligned registers.
*/
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SACC_OFF_SEL   12'h000
`define SACC_OFF_CTLA  12'h004
`define SACC_OFF_CTLB  12'h008
`define SACC_OFF_RESL  12'h00C
`define SACC_OFF_RESH  12'h010
`define SACC_OFF_APPL  12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SACC_SEL_REF_LSB 6
`define SACC_CTLA_EN     7
`define SACC_CTLA_START  6
`define SACC_CTLA_ATE    5
`define SACC_CTLA_FLAG   4
`define SACC_CTLB_LAR    4

// ----------------------------------------------------------------------------
// Reset values and timing counts in ADC clock half cycles, except the sync count in pclk cycles
// ----------------------------------------------------------------------------
`define SACC_SEL_RST     8'h00
`define SACC_TEMP_CODE   6'h22
`define SACC_FREE_SRC    3'h0
`define SACC_HALF_NORM   26
`define SACC_HALF_FIRST  50
`define SACC_SMP_NORM    3
`define SACC_SMP_FIRST   27
`define SACC_SMP_AUTO    4
`define SACC_HALF_AUTO   27
`define SACC_SYNC_CPU    3

`endif

// >>> common/sacc_pkg.sv
/*
  Types shared by the converter control block. Assumes sacc_cfg.svh holds the numbers.
*/
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_IDLE = 2'b00,
    SACC_WAIT = 2'b01,
    SACC_CONV = 2'b11
  } sacc_state_e;
endpackage

// >>> rtl/sacc_ctrl.sv
/*
  Digital control of a 10-bit successive approximation converter, reached over APB.
  Assumes the analog core returns a code at completion and that triggers come from
  logic on pclk.
*/
// Local design decisions: the APB register port and the address map.
// Overview of operation
// [R1] Result right-justified, left when adjust set.
// [R2] Two-bit reference field picks voltage reference.
// [R3] Six-bit channel and gain selection field.
// [R4] Code 100010 routes the temperature sensor.
// [R5] Selections reach converter only when enabled.
// [R6] Low byte read locks result updates.
// [R7] High byte read unlocks result updates.
// [R8] Complete flag sets even on discarded results.
// [R9] Start bit begins conversion, clears on finish.
// [R10] Channel change waits for current conversion.
// [R11] Trigger rising edge resets prescaler, starts.
// [R12] Edges during conversion ignored; level never restarts.
// [R13] Software clears trigger flag before next event.
// [R14] Own complete flag source free-runs conversions.
// [R15] Start write works with auto-trigger; busy reads one.
// [R16] Prescaler runs only while enabled.
// [R17] Start write begins at next ADC clock edge.
// [R18] 13 cycles normal, 25 first, sampling 1.5/13.5.
// [R19] Completion writes result, flag, clears start.
// [R20] Auto-trigger samples at 2, finishes 13.5; code counts from zero, sampling at 2.5 and finishing at 14.
// [R21] Free running samples 2.5, spans 14 cycles.
// [R22] Software keeps ADC clock 50 to 200 kHz.
// [R23] Selection frozen during conversion, tracks late.
// [R24] Prescaler divides by power of two.
`timescale 1ns/1ps
`include "sacc_cfg.svh"

module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int RES_W = 10
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger sources, same clock
  input  wire logic [7:0]  trig_src,
  // Analog core
  input  wire logic [9:0]  conv_code,
  output logic      [1:0]  ana_ref_sel,
  output logic      [5:0]  ana_chan_sel,
  output logic             ana_gain_20x,
  output logic             ana_temp_sel,
  output logic             ana_diff,
  output logic             ana_enable,
  output logic             ana_sample,
  output logic             conv_done
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0]  sel_q;
  logic [7:0]  sel_buf_q;
  logic        en_q, ate_q, flag_q, start_q, lar_q, lock_q, first_q;
  logic [2:0]  ps_q;
  logic [2:0]  ts_q;
  logic [6:0]  div_q;
  logic        half_q;
  logic [5:0]  hcnt_q;
  logic [5:0]  hend_q;
  logic [5:0]  hsmp_q;
  logic [1:0]  sync_q;
  logic        trig_prev_q;
  logic [9:0]  res_q;
  sacc_state_e st_q;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_sel  = paddr == `SACC_OFF_SEL;
  wire hit_ctla = paddr == `SACC_OFF_CTLA;
  wire hit_ctlb = paddr == `SACC_OFF_CTLB;
  wire hit_resl = paddr == `SACC_OFF_RESL;
  wire hit_resh = paddr == `SACC_OFF_RESH;
  wire hit_any  = hit_sel | hit_ctla | hit_ctlb | hit_resl | hit_resh;
  wire wr_ctla  = wr & hit_ctla;

  // --------------------------------------------------------------------------
  // Prescaler and ADC clock half-cycle enable
  // --------------------------------------------------------------------------
  function automatic logic [6:0] div_mask(input logic [2:0] ps);
    div_mask = (ps == 3'h0) ? 7'h00 : 7'(7'h7F >> (3'h7 - ps));
  endfunction

  wire       trig_sel   = trig_src[ts_q];
  wire       trig_edge  = trig_sel & ~trig_prev_q;
  wire       free_mode  = ts_q == `SACC_FREE_SRC;
  wire       auto_fire  = en_q & ate_q & ~free_mode & trig_edge & (st_q == SACC_IDLE); // R12
  wire [6:0] msk        = div_mask(ps_q);
  wire       half_tick  = en_q & (((div_q & msk) == msk) | (ps_q == 3'h0)); // R24
  wire       rise_tick  = half_tick & half_q;
  wire       done_tick  = (st_q == SACC_CONV) & half_tick & (hcnt_q == hend_q);
  wire       free_again = en_q & ate_q & free_mode; // R14
  wire       write_res  = done_tick & ~lock_q; // R6
  wire [9:0] code       = conv_code[RES_W-1:0];
  wire [15:0] res_pack  = lar_q ? {code, 6'h00} : {6'h00, code}; // R1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 7'h00;
      half_q <= 1'b0;
    end else if (!en_q || auto_fire) begin // R16 R11
      div_q  <= 7'h00;
      half_q <= 1'b0;
    end else if (half_tick) begin
      div_q  <= 7'h00;
      half_q <= ~half_q;
    end else begin
      div_q  <= div_q + 7'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= SACC_IDLE;
      hcnt_q      <= 6'h00;
      hend_q      <= 6'h00;
      hsmp_q      <= 6'h00;
      sync_q      <= 2'h0;
      first_q     <= 1'b1;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel;
      if (!en_q) begin
        st_q    <= SACC_IDLE;
        first_q <= 1'b1;
      end else begin
        case (st_q)
          SACC_IDLE: begin
            if (auto_fire) begin // R20
              st_q   <= SACC_WAIT;
              sync_q <= 2'(`SACC_SYNC_CPU - 1);
              hend_q <= 6'(first_q ? `SACC_HALF_FIRST : `SACC_HALF_AUTO);
              hsmp_q <= 6'(first_q ? `SACC_SMP_FIRST : `SACC_SMP_AUTO);
              hcnt_q <= 6'h00;
            end else if (start_q && rise_tick) begin // R17 R18
              st_q   <= SACC_CONV;
              hend_q <= 6'(first_q ? `SACC_HALF_FIRST : `SACC_HALF_NORM);
              hsmp_q <= 6'(first_q ? `SACC_SMP_FIRST : `SACC_SMP_NORM);
              hcnt_q <= 6'h01;
            end
          end
          SACC_WAIT: begin
            if (sync_q == 2'h0) begin
              st_q <= SACC_CONV;
            end else begin
              sync_q <= sync_q - 2'h1;
            end
          end
          SACC_CONV: begin
            if (done_tick) begin
              first_q <= 1'b0;
              if (free_again) begin // R21
                // Counting from one gives the full 28 half cycles, sampling on the fifth.
                hcnt_q <= 6'h01;
                hend_q <= 6'(`SACC_HALF_NORM + 2);
                hsmp_q <= 6'(`SACC_SMP_NORM + 2);
              end else begin
                st_q <= SACC_IDLE;
              end
            end else if (half_tick) begin
              hcnt_q <= hcnt_q + 6'h01;
            end
          end
          default: st_q <= SACC_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control and status registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q   <= `SACC_SEL_RST;
      en_q    <= 1'b0;
      ate_q   <= 1'b0;
      ps_q    <= 3'h0;
      ts_q    <= 3'h0;
      lar_q   <= 1'b0;
      start_q <= 1'b0;
      flag_q  <= 1'b0;
      lock_q  <= 1'b0;
      res_q   <= 10'h000;
    end else begin
      if (wr && hit_sel) begin
        sel_q <= pwdata[7:0];
      end
      if (wr && hit_ctlb) begin
        lar_q <= pwdata[`SACC_CTLB_LAR];
        ts_q  <= pwdata[2:0];
      end
      if (wr_ctla) begin
        en_q  <= pwdata[`SACC_CTLA_EN];
        ate_q <= pwdata[`SACC_CTLA_ATE];
        ps_q  <= pwdata[2:0];
      end
      // Setting wins over a software clear in the same cycle.
      if (done_tick) begin
        flag_q <= 1'b1; // R8 R19
      end else if (wr_ctla && pwdata[`SACC_CTLA_FLAG]) begin
        flag_q <= 1'b0;
      end
      if (wr_ctla && pwdata[`SACC_CTLA_START] && pwdata[`SACC_CTLA_EN]) begin
        start_q <= 1'b1; // R9 R15
      end else if (auto_fire) begin
        start_q <= 1'b1; // R15
      end else if (done_tick && !free_again) begin
        start_q <= 1'b0; // R19
      end else if (!en_q) begin
        start_q <= 1'b0;
      end
      if (write_res) begin
        res_q <= code; // R6
      end
      if (rd && hit_resh) begin
        lock_q <= 1'b0; // R7
      end else if (rd && hit_resl) begin
        lock_q <= 1'b1; // R6
      end
    end
  end

  // --------------------------------------------------------------------------
  // Selection buffer and analog drive
  // --------------------------------------------------------------------------
  wire tracking = (st_q != SACC_CONV) | (hcnt_q >= hend_q - 6'h02); // R23 R10
  wire [15:0] res_view = lar_q ? {res_q, 6'h00} : {6'h00, res_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_buf_q    <= `SACC_SEL_RST;
      ana_ref_sel  <= 2'h0;
      ana_chan_sel <= 6'h00;
      ana_gain_20x <= 1'b0;
      ana_temp_sel <= 1'b0;
      ana_diff     <= 1'b0;
      ana_enable   <= 1'b0;
      ana_sample   <= 1'b0;
      conv_done    <= 1'b0;
    end else begin
      if (tracking) begin
        sel_buf_q <= sel_q;
      end
      ana_enable   <= en_q;
      ana_ref_sel  <= en_q ? sel_buf_q[`SACC_SEL_REF_LSB +: 2] : 2'h0; // R5 R2
      ana_chan_sel <= en_q ? sel_buf_q[5:0] : 6'h00; // R5 R3
      ana_temp_sel <= en_q & (sel_buf_q[5:0] == `SACC_TEMP_CODE); // R4
      ana_diff     <= en_q & (sel_buf_q[5] | sel_buf_q[4] | sel_buf_q[3]) &
                      (sel_buf_q[5:0] != `SACC_TEMP_CODE);
      ana_gain_20x <= en_q & (sel_buf_q[5] | sel_buf_q[4] | sel_buf_q[3]) &
                      (sel_buf_q[5:0] != `SACC_TEMP_CODE) & sel_buf_q[0]; // R3
      ana_sample   <= (st_q == SACC_CONV) & half_tick & (hcnt_q == hsmp_q);
      conv_done    <= done_tick;
    end
  end

  // --------------------------------------------------------------------------
  // APB read path
  // --------------------------------------------------------------------------
  wire [31:0] rd_mux =
      hit_sel  ? {24'h000000, sel_q} :
      hit_ctla ? {24'h000000, en_q, start_q, ate_q, flag_q, 1'b0, ps_q} :
      hit_ctlb ? {24'h000000, 3'h0, lar_q, 1'b0, ts_q} :
      hit_resl ? {24'h000000, res_view[7:0]} :
      hit_resh ? {24'h000000, res_view[15:8]} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_lock_hold;
    @(posedge pclk) disable iff (!presetn)
      (lock_q && done_tick) |=> $stable(res_q);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("result changed while locked"); // R6

  property p_unlock;
    @(posedge pclk) disable iff (!presetn)
      (rd && hit_resh) |=> !lock_q;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high byte read did not unlock"); // R7

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      done_tick |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("complete flag not set"); // R8

  property p_start_clear;
    @(posedge pclk) disable iff (!presetn)
      (done_tick && !free_again && !wr_ctla && !auto_fire) |=> !start_q;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared"); // R9

  property p_busy_start;
    @(posedge pclk) disable iff (!presetn)
      (st_q == SACC_CONV && !done_tick) |-> start_q;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start bit low while busy"); // R15

  property p_no_edge_busy;
    @(posedge pclk) disable iff (!presetn)
      (st_q == SACC_CONV && trig_edge) |=> (st_q != SACC_WAIT);
  endproperty
  a_no_edge_busy: assert property (p_no_edge_busy) else $error("trigger taken while busy"); // R12

  property p_prescale_off;
    @(posedge pclk) disable iff (!presetn)
      !en_q |=> (div_q == 7'h00) && !half_q;
  endproperty
  a_prescale_off: assert property (p_prescale_off) else $error("prescaler ran while disabled"); // R16

  property p_auto_sync;
    @(posedge pclk) disable iff (!presetn)
      auto_fire |=> (st_q == SACC_WAIT) [*3] ##1 (st_q == SACC_CONV);
  endproperty
  a_auto_sync: assert property (p_auto_sync) else $error("trigger sync not three cycles"); // R20

  property p_temp;
    @(posedge pclk) disable iff (!presetn)
      (en_q && sel_buf_q[5:0] == `SACC_TEMP_CODE) |=> ana_temp_sel;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature sensor not routed"); // R4

endmodule

// >>> tb/sacc_ana_model.sv
/*
  Behavioural analog core facing the converter control block.
  Assumes sample and completion pulses on pclk from the control block.
*/
`timescale 1ns/1ps

module sacc_ana_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control block side
  input  wire logic [1:0] ana_ref_sel,
  input  wire logic [5:0] ana_chan_sel,
  input  wire logic       ana_sample,
  input  wire logic       conv_done,
  output logic      [9:0] conv_code
);
  logic [9:0] code_q;
  logic       hold_q;

  // --------------------------------------------------------------------------
  // Sample and hold
  // --------------------------------------------------------------------------
  // Outside a hold the code toggles every cycle, so a late read matches only on alternate cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 10'h155;
      hold_q <= 1'b0;
    end else if (ana_sample) begin
      code_q <= {ana_ref_sel, ana_chan_sel, 2'b10};
      hold_q <= 1'b1;
    end else if (conv_done) begin
      hold_q <= 1'b0;
    end else if (!hold_q) begin
      code_q <= ~code_q;
    end
  end

  assign conv_code = code_q;
endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for the converter control block.
  Assumes zero-wait APB and prescale 0 giving one ADC half cycle per pclk, except for one conversion run at prescale 2.
*/
`timescale 1ns/1ps
`include "sacc_cfg.svh"

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  trig_src;
  logic [9:0]  conv_code, code;
  logic [1:0]  ana_ref_sel;
  logic [5:0]  ana_chan_sel;
  logic        ana_gain_20x, ana_temp_sel, ana_diff, ana_enable, ana_sample, conv_done;
  int          fail_count, checks, cyc, n;

  sacc_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_src(trig_src), .conv_code(conv_code), .ana_ref_sel(ana_ref_sel),
    .ana_chan_sel(ana_chan_sel), .ana_gain_20x(ana_gain_20x), .ana_temp_sel(ana_temp_sel),
    .ana_diff(ana_diff), .ana_enable(ana_enable), .ana_sample(ana_sample), .conv_done(conv_done)
  );

  sacc_ana_model i_model (
    .pclk(pclk), .presetn(presetn), .ana_ref_sel(ana_ref_sel), .ana_chan_sel(ana_chan_sel),
    .ana_sample(ana_sample), .conv_done(conv_done), .conv_code(conv_code)
  );

  // --------------------------------------------------------------------------
  // Clock and timeout
  // --------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Returns with n holding the cycles waited for the completion pulse.
  task automatic wdone();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_done !== 1'b1 && n < 300);
    if (conv_done !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask

  task automatic ndone(input int c);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      if (conv_done === 1'b1) n++;
    end
  endtask

  function automatic logic [31:0] inr(input int lo, input int hi);
    return {31'h0, n >= lo && n <= hi};
  endfunction

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig_src = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctla_rst", `SACC_OFF_CTLA, 32'h0);
    rdchk("unmapped", 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, serr});
    apb(1'b1, `SACC_OFF_SEL, 32'h62);
    @(posedge pclk);
    chk("temp_off", 32'h0, {31'h0, ana_temp_sel});
    chk("ref_off", 32'h0, {30'h0, ana_ref_sel});
    chk("ana_en_off", 32'h0, {31'h0, ana_enable});
    apb(1'b1, `SACC_OFF_CTLA, 32'h80);
    repeat (2) @(posedge pclk);
    chk("ana_en_on", 32'h1, {31'h0, ana_enable});
    chk("temp_on", 32'h1, {31'h0, ana_temp_sel});
    chk("ref_on", 32'h1, {30'h0, ana_ref_sel});
    apb(1'b1, `SACC_OFF_CTLA, 32'hC0);
    wdone();
    chk("first_len", 32'h1, inr(48, 56));
    rdchk("ctla_done", `SACC_OFF_CTLA, 32'h90);
    code = {2'b01, 6'h22, 2'b10};
    rdchk("low", `SACC_OFF_RESL, {24'h0, code[7:0]});
    rdchk("high", `SACC_OFF_RESH, {30'h0, code[9:8]});
    apb(1'b1, `SACC_OFF_SEL, 32'h09);
    // Register, selection buffer and analog drive each take one edge.
    repeat (3) @(posedge pclk);
    chk("diff_gain", 32'h3, {30'h0, ana_diff, ana_gain_20x});
    apb(1'b1, `SACC_OFF_CTLA, 32'hD0);
    rdchk("busy", `SACC_OFF_CTLA, 32'hC0);
    apb(1'b1, `SACC_OFF_SEL, 32'h03);
    wdone();
    code = {2'b00, 6'h09, 2'b10};
    rdchk("low_old_chan", `SACC_OFF_RESL, {24'h0, code[7:0]});
    chk("chan_new", 32'h3, {26'h0, ana_chan_sel});
    chk("single", 32'h0, {30'h0, ana_diff, ana_gain_20x});
    // Low byte was read above, so this completion must be discarded.
    apb(1'b1, `SACC_OFF_CTLA, 32'hD0);
    wdone();
    rdchk("flag_locked", `SACC_OFF_CTLA, 32'h90);
    rdchk("high_locked", `SACC_OFF_RESH, {30'h0, code[9:8]});
    rdchk("low_locked", `SACC_OFF_RESL, {24'h0, code[7:0]});
    apb(1'b0, `SACC_OFF_RESH, 32'h0);
    apb(1'b1, `SACC_OFF_CTLA, 32'hD0);
    wdone();
    chk("norm_len", 32'h1, inr(24, 31));
    code = {2'b00, 6'h03, 2'b10};
    rdchk("low_new", `SACC_OFF_RESL, {24'h0, code[7:0]});
    rdchk("high_new", `SACC_OFF_RESH, {30'h0, code[9:8]});
    apb(1'b1, `SACC_OFF_CTLB, 32'h10);
    apb(1'b1, `SACC_OFF_CTLA, 32'hD0);
    wdone();
    rdchk("low_left", `SACC_OFF_RESL, {24'h0, code[1:0], 6'h0});
    rdchk("high_left", `SACC_OFF_RESH, {24'h0, code[9:2]});
    apb(1'b1, `SACC_OFF_CTLA, 32'hD2);
    wdone();
    chk("ps2_len", 32'h1, inr(100, 116));
    apb(1'b1, `SACC_OFF_CTLB, 32'h01);
    apb(1'b1, `SACC_OFF_CTLA, 32'hF0);
    wdone();
    chk("ate_start", 32'h1, inr(24, 31));
    trig_src <= 8'h02;
    wdone();
    chk("trig_len", 32'h1, inr(28, 36));
    ndone(80);
    chk("level_hold", 32'h0, n);
    trig_src <= 8'h00;
    @(posedge pclk);
    trig_src <= 8'h02;
    repeat (6) @(posedge pclk);
    trig_src <= 8'h00;
    repeat (2) @(posedge pclk);
    trig_src <= 8'h02;
    ndone(100);
    chk("edge_ignored", 32'h1, n);
    trig_src <= 8'h00;
    apb(1'b1, `SACC_OFF_CTLB, 32'h00);
    apb(1'b1, `SACC_OFF_CTLA, 32'hF0);
    wdone();
    wdone();
    chk("free_len", 32'h1, inr(27, 30));
    rdchk("free_busy", `SACC_OFF_CTLA, 32'hF0);
    print_verdict();
  end
endmodule
